// *** src/flic_arbiter.sv ***
// Combinational level and polling-order arbiter over the six request sources.
`default_nettype none

module flic_arbiter (
  input  wire logic                  i_global_en,
  input  wire flic_pkg::flic_src_vec_t i_pending,
  input  wire flic_pkg::flic_src_vec_t i_enable,
  input  wire flic_pkg::flic_src_vec_t i_prio_high,
  input  wire flic_pkg::flic_src_vec_t i_prio_low,
  output logic                       o_valid,
  output flic_pkg::flic_src_t        o_src,
  output flic_pkg::flic_level_t      o_level
);

  flic_pkg::flic_level_t src_level [flic_pkg::NUM_SRC];
  flic_pkg::flic_src_vec_t eligible;

  // --------------------------------------------------------------------------
  // Per-source level and eligibility
  // --------------------------------------------------------------------------
  for (genvar g = 0; g < flic_pkg::NUM_SRC; g++) begin : g_src
    assign src_level[g] = {i_prio_high[g], i_prio_low[g]};
    assign eligible[g]  = i_pending[g] & i_enable[g] & i_global_en;
  end

  // --------------------------------------------------------------------------
  // Selection
  // --------------------------------------------------------------------------
  // Scanning from the last source down with >= lets an earlier source in the
  // polling order take over on an equal level, so the lowest-numbered bit wins every tie.
  always_comb begin
    o_valid = 1'b0;
    o_src   = '0;
    o_level = '0;
    for (int i = flic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!o_valid || src_level[i] >= o_level)) begin
        o_valid = 1'b1;
        o_src   = flic_pkg::flic_src_t'(i);
        o_level = src_level[i];
      end
    end
  end

endmodule // flic_arbiter

`default_nettype wire

// *** src/flic_level_track.sv ***
// In-service level tracker: one flag per priority level, released on return.
`default_nettype none

module flic_level_track (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_push,
  input  wire flic_pkg::flic_level_t i_push_level,
  input  wire logic                  i_pop,
  output flic_pkg::flic_lvl_vec_t    o_in_service,
  output logic                       o_busy,
  output flic_pkg::flic_level_t      o_cur_level
);

  typedef struct packed {
    flic_pkg::flic_lvl_vec_t in_service;
  } flic_track_s;

  flic_track_s s;
  flic_track_s next_s;

  // --------------------------------------------------------------------------
  // Current level is the highest flag that is set
  // --------------------------------------------------------------------------
  always_comb begin
    o_cur_level = '0;
    for (int i = 0; i < flic_pkg::NUM_LVL; i++) begin
      if (s.in_service[i]) begin
        o_cur_level = flic_pkg::flic_level_t'(i);
      end
    end
  end

  assign o_busy       = |s.in_service;
  assign o_in_service = s.in_service;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // A return always belongs to the routine at the top level, so the pop is
  // applied before a push that arrives in the same cycle.
  always_comb begin
    next_s = s;
    if (i_pop && o_busy) begin
      next_s.in_service[o_cur_level] = 1'b0;
    end
    if (i_push) begin
      next_s.in_service[i_push_level] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s <= '0;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

endmodule // flic_level_track

`default_nettype wire

// *** src/flic_params.svh ***
// Register indices, field positions, reset values and masks of the interrupt controller.
`ifndef FLIC_PARAMS_SVH
`define FLIC_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define FLIC_IDX_POWER_CTRL    8'h87
`define FLIC_IDX_ENABLE        8'hA8
`define FLIC_IDX_PRIO_HIGH     8'hB7
`define FLIC_IDX_PRIO_LOW      8'hB8
`define FLIC_IDX_ENABLE_SET    8'hC0
`define FLIC_IDX_ENABLE_CLR    8'hC1
`define FLIC_IDX_PRIO_LOW_SET  8'hC2
`define FLIC_IDX_PRIO_LOW_CLR  8'hC3
`define FLIC_IDX_STATUS        8'hC4

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define FLIC_BIT_GLOBAL_EN     7
`define FLIC_BIT_SLEEP         0
`define FLIC_STAT_PEND_LSB     0
`define FLIC_STAT_INSVC_LSB    8
`define FLIC_STAT_VECTOR_LSB   12
`define FLIC_STAT_LEVEL_LSB    16
`define FLIC_STAT_REQ_BIT      20
`define FLIC_STAT_SLEEP_BIT    21

// ----------------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------------
`define FLIC_RST_ENABLE        8'h00
`define FLIC_RST_PRIO          8'h00
`define FLIC_RST_SLEEP         1'b0
`define FLIC_MASK_ENABLE       8'hBF
`define FLIC_MASK_PRIO         8'h3F
`define FLIC_MASK_BIT_OP       8'h07

`endif

// *** src/flic_pkg.sv ***
// Shared types of the four-level interrupt controller.
`default_nettype none

package flic_pkg;

  localparam int unsigned NUM_SRC = 6;
  localparam int unsigned NUM_LVL = 4;

  typedef logic [1:0]         flic_level_t;
  typedef logic [2:0]         flic_src_t;
  typedef logic [NUM_SRC-1:0] flic_src_vec_t;
  typedef logic [NUM_LVL-1:0] flic_lvl_vec_t;

endpackage : flic_pkg

`default_nettype wire

// *** src/flic_top.sv ***
// Four-level interrupt controller with APB register access.
//
// Behaviour
// - six sources, each with its own vector.
// - per-source enable gates every request.
// - enable bit 7 globally gates all requests.
// - level is high bit over low bit.
// - only strictly higher level preempts service.
// - top-level service blocks every other request.
// - higher pending level wins over lower.
// - polling order breaks ties within one level.
// - enable register layout, bit 6 reserved.
// - enable resets to zero; bit access supported.
// - low priority register, bit accessible.
// - high priority register, whole-word access only.
// - reserved bits read zero, written zero.
// - interrupt or reset clears sleep request bit.
// - any forwarded interrupt ends sleep.
`include "flic_params.svh"
`default_nettype none

module flic_top #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  // APB slave
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // Request sources
  input  wire logic              i_ext_request_pin0_n,
  input  wire logic              i_ext_request_pin1_n,
  input  wire logic              i_timer0_ovf,
  input  wire logic              i_timer1_ovf,
  input  wire logic              i_timer2_ovf,
  input  wire logic              i_serial_req,
  // CPU core
  output logic                   o_irq_req,
  output logic [2:0]             o_irq_vector,
  output logic [1:0]             o_irq_level,
  input  wire logic              i_irq_ack,
  input  wire logic              i_irq_return,
  output logic                   o_cpu_sleep_request
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]            ext_meta;
    logic [1:0]            ext_sync;
    logic [7:0]            enable;
    logic [7:0]            prio_high;
    logic [7:0]            prio_low;
    logic                  sleep;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  irq_req;
    flic_pkg::flic_src_t   vector;
    flic_pkg::flic_level_t level;
  } flic_top_s;

  flic_top_s s;
  flic_top_s next_s;
  flic_top_s rst_val;

  flic_pkg::flic_src_vec_t pending;
  flic_pkg::flic_lvl_vec_t in_service;
  flic_pkg::flic_level_t   cur_level;
  flic_pkg::flic_level_t   win_level;
  flic_pkg::flic_src_t     win_src;
  logic                    win_valid;
  logic                    busy;
  logic                    forward;
  logic                    take;
  logic                    setup;
  logic                    access_done;
  logic                    addr_ok;
  logic                    hit_err;
  logic [7:0]              index;
  logic [31:0]             read_val;

  // --------------------------------------------------------------------------
  // Sources and arbitration
  // --------------------------------------------------------------------------
  // Bit positions equal the polling order, so the arbiter needs no remapping.
  assign pending = {i_timer2_ovf, i_serial_req, i_timer1_ovf,
                    s.ext_sync[1], i_timer0_ovf, s.ext_sync[0]};

  flic_arbiter u_arbiter (
    .i_global_en (s.enable[`FLIC_BIT_GLOBAL_EN]),
    .i_pending   (pending),
    .i_enable    (s.enable[flic_pkg::NUM_SRC-1:0]),
    .i_prio_high (s.prio_high[flic_pkg::NUM_SRC-1:0]),
    .i_prio_low  (s.prio_low[flic_pkg::NUM_SRC-1:0]),
    .o_valid     (win_valid),
    .o_src       (win_src),
    .o_level     (win_level)
  );

  // Only a request taken while the controller is presenting it counts.
  assign take = i_irq_ack & s.irq_req;

  flic_level_track u_level_track (
    .i_sys_clk    (i_sys_clk),
    .i_rst_n      (i_rst_n),
    .i_clk_en     (i_clk_en),
    .i_push       (take),
    .i_push_level (s.level),
    .i_pop        (i_irq_return),
    .o_in_service (in_service),
    .o_busy       (busy),
    .o_cur_level  (cur_level)
  );

  // Level 3 can never be exceeded, so a level 3 service blocks everything.
  assign forward = win_valid && (!busy || win_level > cur_level);

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  assign setup       = i_psel & ~i_penable;
  assign access_done = i_psel & i_penable & s.pready;
  assign index       = i_paddr[9:2];
  assign addr_ok     = (i_paddr[1:0] == 2'b00) && (i_paddr[ADDR_W-1:10] == '0);

  always_comb begin
    read_val = '0;
    hit_err  = 1'b0;
    if (!addr_ok) begin
      hit_err = 1'b1;
    end else begin
      unique case (index)
        `FLIC_IDX_POWER_CTRL:   read_val[`FLIC_BIT_SLEEP] = s.sleep;
        `FLIC_IDX_ENABLE:       read_val[7:0] = s.enable & `FLIC_MASK_ENABLE;
        `FLIC_IDX_PRIO_HIGH:    read_val[7:0] = s.prio_high & `FLIC_MASK_PRIO;
        `FLIC_IDX_PRIO_LOW:     read_val[7:0] = s.prio_low & `FLIC_MASK_PRIO;
        `FLIC_IDX_ENABLE_SET,
        `FLIC_IDX_ENABLE_CLR,
        `FLIC_IDX_PRIO_LOW_SET,
        `FLIC_IDX_PRIO_LOW_CLR: read_val = '0;
        `FLIC_IDX_STATUS: begin
          hit_err = i_pwrite;
          read_val[`FLIC_STAT_PEND_LSB +: flic_pkg::NUM_SRC] = pending;
          read_val[`FLIC_STAT_INSVC_LSB +: flic_pkg::NUM_LVL] = in_service;
          read_val[`FLIC_STAT_VECTOR_LSB +: 3] = s.vector;
          read_val[`FLIC_STAT_LEVEL_LSB +: 2] = s.level;
          read_val[`FLIC_STAT_REQ_BIT] = s.irq_req;
          read_val[`FLIC_STAT_SLEEP_BIT] = s.sleep;
        end
        default:                hit_err = 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Reset image
  // --------------------------------------------------------------------------
  always_comb begin
    rst_val           = '0;
    rst_val.enable    = `FLIC_RST_ENABLE;
    rst_val.prio_high = `FLIC_RST_PRIO;
    rst_val.prio_low  = `FLIC_RST_PRIO;
    rst_val.sleep     = `FLIC_RST_SLEEP;
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Pins are active low and asynchronous to the core clock.
    next_s.ext_meta = {~i_ext_request_pin1_n, ~i_ext_request_pin0_n};
    next_s.ext_sync = s.ext_meta;

    // Zero wait state: the answer is ready in the first access cycle.
    next_s.pready  = setup;
    next_s.pslverr = setup & hit_err;
    next_s.prdata  = setup ? read_val : '0;

    if (access_done && i_pwrite && !s.pslverr) begin
      unique case (index)
        `FLIC_IDX_POWER_CTRL: next_s.sleep = i_pwdata[`FLIC_BIT_SLEEP];
        `FLIC_IDX_ENABLE:     next_s.enable = i_pwdata[7:0] & `FLIC_MASK_ENABLE;
        // The high register has no bit aliases; it is written as a whole word.
        `FLIC_IDX_PRIO_HIGH:  next_s.prio_high = i_pwdata[7:0] & `FLIC_MASK_PRIO;
        `FLIC_IDX_PRIO_LOW:   next_s.prio_low = i_pwdata[7:0] & `FLIC_MASK_PRIO;
        // Single-bit access: the low three write bits name the bit to change.
        `FLIC_IDX_ENABLE_SET:
          next_s.enable[i_pwdata[2:0]] = 1'(`FLIC_MASK_ENABLE >> i_pwdata[2:0]);
        `FLIC_IDX_ENABLE_CLR:
          next_s.enable[i_pwdata[2:0]] = 1'b0;
        `FLIC_IDX_PRIO_LOW_SET:
          next_s.prio_low[i_pwdata[2:0]] = 1'(`FLIC_MASK_PRIO >> i_pwdata[2:0]);
        `FLIC_IDX_PRIO_LOW_CLR:
          next_s.prio_low[i_pwdata[2:0]] = 1'b0;
        default:              next_s.sleep = s.sleep;
      endcase
    end

    // Wake-up overrides a software write in the same cycle so that an
    // interrupt arriving while the core goes to sleep is never lost.
    if (forward || take) begin
      next_s.sleep = 1'b0;
    end

    // The request drops for the cycle after a take, while the tracker
    // records the new level; then it is re-evaluated against that level.
    next_s.irq_req = forward & ~take;
    if (forward) begin
      next_s.vector = win_src;
      next_s.level  = win_level;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s <= rst_val;
    end else if (i_clk_en) begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign o_prdata            = s.prdata;
  assign o_pready            = s.pready;
  assign o_pslverr           = s.pslverr;
  assign o_irq_req           = s.irq_req;
  assign o_irq_vector        = s.vector;
  assign o_irq_level         = s.level;
  assign o_cpu_sleep_request = s.sleep;

endmodule // flic_top

`default_nettype wire

// *** verification/flic_chk.sv ***
// Port-level assertions of the interrupt controller.
`default_nettype none
module flic_chk #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [31:0]       i_pwdata,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              o_irq_req,
  input wire logic [2:0]        o_irq_vector,
  input wire logic [1:0]        o_irq_level,
  input wire logic              i_irq_ack,
  input wire logic              i_irq_return,
  input wire logic              o_cpu_sleep_request
);
  // ------
  // Register and service mirror
  // ------
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] ph;
    logic [7:0] pl;
    logic [7:0] en_d;
    logic [7:0] ph_d;
    logic [7:0] pl_d;
    logic [3:0] svc;
  } flic_chk_s;
  flic_chk_s st;
  flic_chk_s next_st;
  logic      wr;
  assign wr = i_psel && i_penable && o_pready && i_pwrite;
  // Delayed copies line up with the registered request, which lags the registers by one cycle.
  always_comb begin
    next_st = st;
    next_st.en_d = st.en;
    next_st.ph_d = st.ph;
    next_st.pl_d = st.pl;
    if (wr) begin
      case (i_paddr)
        12'h2A0: next_st.en = i_pwdata[7:0];
        12'h2DC: next_st.ph = i_pwdata[7:0];
        12'h2E0: next_st.pl = i_pwdata[7:0];
        12'h300: next_st.en[i_pwdata[2:0]] = 1'b1;
        12'h304: next_st.en[i_pwdata[2:0]] = 1'b0;
        12'h308: next_st.pl[i_pwdata[2:0]] = 1'b1;
        12'h30C: next_st.pl[i_pwdata[2:0]] = 1'b0;
        default: ;
      endcase
    end
    if (i_irq_return) begin
      if (st.svc[3]) next_st.svc[3] = 1'b0;
      else if (st.svc[2]) next_st.svc[2] = 1'b0;
      else if (st.svc[1]) next_st.svc[1] = 1'b0;
      else next_st.svc[0] = 1'b0;
    end
    if (i_irq_ack && o_irq_req) next_st.svc[o_irq_level] = 1'b1;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) st <= '0;
    else st <= next_st;
  end
  // ------
  // Assertions
  // ------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_answer;
    o_pready ##1 !o_pready;
  endsequence
  a_apb_one_wait: assert property (s_setup |=> s_answer)
    else $error("ready not a single cycle after setup");
  a_apb_bad_addr: assert property ((s_setup and (i_paddr[1:0] != 2'b00)) |=> o_pready && o_pslverr)
    else $error("misaligned access not refused");
  a_vector_range: assert property (o_irq_req |-> o_irq_vector <= 3'd5)
    else $error("vector outside six sources");
  a_own_enable: assert property (o_irq_req |-> st.en_d[o_irq_vector])
    else $error("disabled source forwarded");
  a_global_gate: assert property (o_irq_req |-> st.en_d[7])
    else $error("request forwarded with global enable off");
  a_level_formed: assert property (o_irq_req |-> o_irq_level == {st.ph_d[o_irq_vector], st.pl_d[o_irq_vector]})
    else $error("level not high bit over low bit");
  a_strict_preempt: assert property (o_irq_req |-> (st.svc >> o_irq_level) == 4'h0)
    else $error("request not above every level in service");
  a_top_blocks: assert property (st.svc[3] |-> !o_irq_req)
    else $error("request shown during top level service");
  a_ack_drops: assert property (o_irq_req && i_irq_ack |=> !o_irq_req)
    else $error("request still shown after acknowledge");
  a_sleep_woken: assert property ($rose(o_irq_req) |-> !o_cpu_sleep_request)
    else $error("sleep bit kept while interrupt forwarded");
endmodule  // flic_chk

bind flic_top flic_chk #(.ADDR_W(ADDR_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_paddr(i_paddr), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_irq_req(o_irq_req), .o_irq_vector(o_irq_vector),
  .o_irq_level(o_irq_level), .i_irq_ack(i_irq_ack), .i_irq_return(i_irq_return),
  .o_cpu_sleep_request(o_cpu_sleep_request));
`default_nettype wire

// *** verification/flic_cpu_model.sv ***
// Behavioural CPU core that acknowledges presented interrupts and returns on command.
`default_nettype none
module flic_cpu_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_irq_req,
  input  wire logic [3:0] i_ack_delay,
  input  wire logic       i_ret_cmd,
  output logic            o_irq_ack,
  output logic            o_irq_return
);
  typedef struct packed {
    logic [3:0] wait_cnt;
    logic       ack;
    logic       ret;
  } flic_cpu_s;
  flic_cpu_s st;
  flic_cpu_s next_st;
  // The acknowledge is a single pulse; the wait restarts so a dropped request is never taken.
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.ret = i_ret_cmd;
    if (st.ack || !i_irq_req) begin
      next_st.wait_cnt = 4'h0;
    end else if (st.wait_cnt == i_ack_delay) begin
      next_st.ack = 1'b1;
    end else begin
      next_st.wait_cnt = st.wait_cnt + 4'h1;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) st <= '0;
    else st <= next_st;
  end
  assign o_irq_ack = st.ack;
  assign o_irq_return = st.ret;
endmodule  // flic_cpu_model
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking testbench of the four-level interrupt controller.
`include "flic_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_EN = {2'b00, `FLIC_IDX_ENABLE, 2'b00};
  localparam logic [11:0] A_PH = {2'b00, `FLIC_IDX_PRIO_HIGH, 2'b00};
  localparam logic [11:0] A_PL = {2'b00, `FLIC_IDX_PRIO_LOW, 2'b00};
  localparam logic [11:0] A_PW = {2'b00, `FLIC_IDX_POWER_CTRL, 2'b00};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  src = 6'h00;
  logic        req;
  logic [2:0]  vec;
  logic [1:0]  lvl;
  logic        ack;
  logic        ret;
  logic        ret_cmd = 1'b0;
  logic [3:0]  dly = 4'h0;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  // Pins 0 and 1 are active low, so their bits are inverted on the way in.
  flic_top dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_paddr(paddr), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_request_pin0_n(~src[0]), .i_timer0_ovf(src[1]),
    .i_ext_request_pin1_n(~src[2]), .i_timer1_ovf(src[3]), .i_serial_req(src[4]),
    .i_timer2_ovf(src[5]), .o_irq_req(req), .o_irq_vector(vec), .o_irq_level(lvl),
    .i_irq_ack(ack), .i_irq_return(ret), .o_cpu_sleep_request());
  flic_cpu_model cpu (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_irq_req(req), .i_ack_delay(dly),
    .i_ret_cmd(ret_cmd), .o_irq_ack(ack), .o_irq_return(ret));
  // ------
  // Shared tasks
  // ------
  task automatic close_out();
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // The trailing idle cycle keeps psel from being lowered and raised in one time step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit here: only the bench timeout may end a stalled transfer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [32:0] q;
    apb(1'b1, a, {24'h00_0000, d}, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    logic [32:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  task automatic rd_err(input logic [11:0] a);
    logic [32:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(33'(q[32]), 33'h0_0000_0001);
  endtask
  task automatic no_req(input int n);
    repeat (n) begin
      @(posedge clk);
      chk(33'(req), 33'h0_0000_0000);
    end
  endtask
  task automatic ret_pulse();
    ret_cmd <= 1'b1;
    @(posedge clk);
    ret_cmd <= 1'b0;
    @(posedge clk);
  endtask
  // Waits for the acknowledge, checks what it took, then retires the source.
  task automatic take(input logic [2:0] v, input logic [1:0] l, input logic pop);
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 64) begin
      @(posedge clk);
      n++;
    end
    chk(33'({ack, vec, lvl}), 33'({1'b1, v, l}));
    src[v] <= 1'b0;
    @(posedge clk);
    if (pop) begin
      repeat (4) @(posedge clk);
      ret_pulse();
    end
  endtask
  task automatic serve(input logic [17:0] vs, input logic [11:0] ls);
    wr(A_EN, 8'h00);
    src <= 6'h3F;
    repeat (4) @(posedge clk);
    wr(A_EN, 8'hBF);
    for (int i = 0; i < 6; i++) take(vs[3*i +: 3], ls[2*i +: 2], 1'b1);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_regs();
    rd(A_EN, 33'h0_0000_0000);
    rd(A_PW, 33'h0_0000_0000);
    // Software keeps every reserved bit at zero when it writes.
    wr(A_EN, 8'hBF);
    rd(A_EN, 33'h0_0000_00BF);
    wr(A_PH, 8'h3F);
    rd(A_PH, 33'h0_0000_003F);
    wr(A_PL, 8'h3F);
    rd(A_PL, 33'h0_0000_003F);
    wr(12'h304, 8'h05);
    wr(12'h304, 8'h07);
    wr(12'h300, 8'h05);
    rd(A_EN, 33'h0_0000_003F);
    wr(12'h30C, 8'h05);
    rd(A_PL, 33'h0_0000_001F);
    rd_err(12'h3FC);
    rd_err(12'h2A1);
    wr(A_PH, 8'h00);
    wr(A_PL, 8'h00);
    wr(A_EN, 8'h00);
  endtask
  task automatic t_gate();
    wr(A_PW, 8'h01);
    rd(A_PW, 33'h0_0000_0001);
    wr(A_EN, 8'h02);
    src <= 6'h02;
    no_req(6);
    wr(A_EN, 8'hBD);
    no_req(6);
    wr(A_EN, 8'h82);
    take(3'd1, 2'd0, 1'b1);
    rd(A_PW, 33'h0_0000_0000);
  endtask
  // Levels: src0 1, src1 2, src2 0, src3 3, src4 2, src5 1.
  task automatic t_nest();
    src[2] <= 1'b1;
    take(3'd2, 2'd0, 1'b0);
    src[0] <= 1'b1;
    take(3'd0, 2'd1, 1'b0);
    src[5] <= 1'b1;
    no_req(8);
    src[3] <= 1'b1;
    take(3'd3, 2'd3, 1'b0);
    src[1] <= 1'b1;
    no_req(8);
    ret_pulse();
    take(3'd1, 2'd2, 1'b1);
    no_req(6);
    ret_pulse();
    take(3'd5, 2'd1, 1'b1);
    ret_pulse();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_gate();
    serve({3'd5, 3'd4, 3'd3, 3'd2, 3'd1, 3'd0}, 12'h000);
    wr(A_PL, 8'h29);
    wr(A_PH, 8'h1A);
    dly <= 4'h3;
    serve({3'd2, 3'd5, 3'd0, 3'd4, 3'd1, 3'd3}, {2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3});
    dly <= 4'h0;
    t_nest();
    close_out();
  end
endmodule  // tb
`default_nettype wire
